// *** inc/slp_pkg.sv ***
// Constants shared by the loop skip multiplexer and its sub-blocks.
// Assumes a 25 MHz system clock and a 32-bit register bus.
package slp_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] ADDR_ID = 8'h14;

    // Control fields
    localparam int CTRL_RELOCK_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Status fields
    localparam int STAT_SEL_LSB = 0;
    localparam int STAT_PRESENT_LSB = 2;
    localparam int STAT_LOCKED_BIT = 4;
    localparam int STAT_REF_ALIVE_BIT = 5;

    // Interrupt event bits
    localparam int IRQ_WIDTH = 5;
    localparam int EVT_PRESENT_LSB = 0;
    localparam int EVT_LOCK_GAIN = 2;
    localparam int EVT_LOCK_LOSS = 3;
    localparam int EVT_SEL_CHANGE = 4;
    localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 5'h00;

    // Arbitrary identification value
    localparam logic [31:0] ID_VALUE = 32'h5A1B_0001;

    // Envelope thresholds in mV peak-to-peak
    localparam int AMP_WIDTH = 12;
    localparam logic [AMP_WIDTH-1:0] PRESENT_ON_MV = 12'h190;
    localparam logic [AMP_WIDTH-1:0] PRESENT_OFF_MV = 12'h064;

    // Phase lock budget in bit times, one bit per system clock
    localparam int LOCK_BITS_MAX = 2500;
    // Reference clock must toggle within this time to be trusted
    localparam int REF_TIMEOUT_NS = 400;
    localparam int CLK_PERIOD_NS = 40;
    localparam int REF_TIMEOUT_CYC = REF_TIMEOUT_NS / CLK_PERIOD_NS;

    typedef enum logic {
        SLP_ACQUIRE,
        SLP_LOCKED
    } slp_lock_t;
endpackage

// *** inc/slp_det_if.sv ***
// Carrier between the top level and one signal-present detector.
// Assumes amplitude is a measured value in mV from the front end.
`timescale 1ns/10ps
interface slp_det_if;
    logic [11:0] amp_mv;
    logic present;
    modport det (input amp_mv, output present);
    modport top (output amp_mv, input present);
endinterface

// *** hw/slp_cell.sv ***
// One skip cell: steers the partner output between own and partner input.
// Assumes select already resolved for the pull-up.
`timescale 1ns/10ps
module slp_cell (
    input wire logic own_in,
    input wire logic partner_in,
    input wire logic insert_in,
    output logic partner_out
);
    // Pure gating, no handshake, so a select change acts at once
    always_comb begin
        partner_out = insert_in ? own_in : partner_in;
    end
endmodule

// *** hw/slp_det.sv ***
// Envelope signal-present decision with hysteresis.
// Assumes one amplitude sample per system clock.
`timescale 1ns/10ps
module slp_det (
    input wire logic clk_in,
    input wire logic rstn_in,
    slp_det_if.det port
);
    logic present_q;
    logic present_d;

    // Between thresholds the level is undefined; holding avoids chatter
    always_comb begin
        present_d = present_q;
        if (port.amp_mv >= slp_pkg::PRESENT_ON_MV) begin
            present_d = 1'b1;
        end else if (port.amp_mv <= slp_pkg::PRESENT_OFF_MV) begin
            present_d = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            present_q <= 1'b0;
        end else begin
            present_q <= present_d;
        end
    end

    assign port.present = present_q;
endmodule

// *** hw/slp_mux_top.sv ***
// Two-cell serial loop skip multiplexer with recovery lock tracking,
// dual signal-present detect and an Avalon-MM register slave.
// Assumes all pins are synchronous to CLK_SYS_IN, one bit per clock.
// Function
// - Select high puts the cell's drive in the loop; select low skips it.
// - Inserted, traffic leaves on the node output and returns on node input.
// - Entry: out 1 carries in 0; out 0 is in 1 if select 1 is high, else in 0.
// - Exit: out 0 carries in 1; out 1 is in 0 if select 0 is high, else in 1.
// - Present 1 watches the entry cable and present 0 the exit cable.
// - Present is 1 from 400 mV, 0 at or below 100 mV, undefined between.
// - Select pins pull up; the board is advised to float a pin for high.
// - Recovery takes its frequency from the reference clock input.
// - The recovery circuit locks onto incoming data within 2500 bit times.
`timescale 1ns/10ps
module slp_mux_top #(
    parameter int LOCK_BITS = slp_pkg::LOCK_BITS_MAX
) (
    input wire logic CLK_SYS_IN,
    input wire logic RSTN_IN,
    input wire logic REF_CLK_IN,
    input wire logic [1:0] DRIVE_SIDE_INPUT_IN,
    output logic [1:0] DRIVE_SIDE_OUTPUT_OUT,
    input wire logic [1:0] SKIP_N_IN,
    input wire logic [1:0] SKIP_N_DRIVEN_IN,
    input wire logic [11:0] INPUT0_AMP_MV_IN,
    input wire logic [11:0] INPUT1_AMP_MV_IN,
    output logic [1:0] SIGNAL_PRESENT_OUT,
    output logic LOCKED_OUT,
    input wire logic [7:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    output logic IRQ_OUT
);
    localparam int CNT_W = 12;
    localparam int TMO_W = 8;

    generate
        if (LOCK_BITS < 1 || LOCK_BITS > slp_pkg::LOCK_BITS_MAX) begin : g_chk
            $error("LOCK_BITS must lie in 1..2500");
        end
    endgenerate

    // Select resolution: undriven pin reads high through the pull-up
    logic [1:0] insert;
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            insert[i] = SKIP_N_DRIVEN_IN[i] ? SKIP_N_IN[i] : 1'b1;
        end
    end

    // Cell k feeds output k^1 from input k when inserted, else passes
    // input k^1 through; this covers both board wirings at once.
    logic [1:0] route;
    slp_cell u_cell0 (
        .own_in(DRIVE_SIDE_INPUT_IN[0]),
        .partner_in(DRIVE_SIDE_INPUT_IN[1]),
        .insert_in(insert[0]),
        .partner_out(route[1])
    );
    slp_cell u_cell1 (
        .own_in(DRIVE_SIDE_INPUT_IN[1]),
        .partner_in(DRIVE_SIDE_INPUT_IN[0]),
        .insert_in(insert[1]),
        .partner_out(route[0])
    );

    // One register stage so outputs leave a flop; fixed one-clock delay
    logic [1:0] dout_q;
    logic [1:0] dout_d;
    always_comb begin
        dout_d = route;
    end

    // Signal-present detectors: [1] watches input 0, [0] watches input 1
    slp_det_if det_entry ();
    slp_det_if det_exit ();
    assign det_entry.amp_mv = INPUT0_AMP_MV_IN;
    assign det_exit.amp_mv = INPUT1_AMP_MV_IN;
    slp_det u_det_entry (
        .clk_in(CLK_SYS_IN),
        .rstn_in(RSTN_IN),
        .port(det_entry)
    );
    slp_det u_det_exit (
        .clk_in(CLK_SYS_IN),
        .rstn_in(RSTN_IN),
        .port(det_exit)
    );
    logic [1:0] present;
    always_comb begin
        present = {det_entry.present, det_exit.present};
    end

    // Recovery lock tracking, referenced to the reference clock input
    slp_pkg::slp_lock_t lock_q;
    slp_pkg::slp_lock_t lock_d;
    logic ref_q;
    logic ref_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [TMO_W-1:0] tmo_q;
    logic [TMO_W-1:0] tmo_d;
    logic ref_alive;
    logic cable_present;
    logic relock;

    always_comb begin
        ref_d = REF_CLK_IN;
        tmo_d = tmo_q;
        if (REF_CLK_IN != ref_q) begin
            tmo_d = '0;
        end else if (tmo_q != TMO_W'(slp_pkg::REF_TIMEOUT_CYC)) begin
            tmo_d = tmo_q + 1'b1;
        end
        ref_alive = (tmo_q != TMO_W'(slp_pkg::REF_TIMEOUT_CYC));
        // Cable input is whichever input the inserted cell's wiring feeds
        cable_present = insert[0] ? present[1] : present[0];
        lock_d = lock_q;
        cnt_d = cnt_q;
        if (!ref_alive || !cable_present || relock) begin
            lock_d = slp_pkg::SLP_ACQUIRE;
            cnt_d = '0;
        end else begin
            case (lock_q)
                slp_pkg::SLP_ACQUIRE: begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == CNT_W'(LOCK_BITS - 1)) begin
                        lock_d = slp_pkg::SLP_LOCKED;
                    end
                end
                slp_pkg::SLP_LOCKED: begin
                    cnt_d = cnt_q;
                end
                default: begin
                    lock_d = slp_pkg::SLP_ACQUIRE;
                end
            endcase
        end
    end

    // Register slave state
    logic wait_q;
    logic wait_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic [slp_pkg::IRQ_WIDTH-1:0] ists_q;
    logic [slp_pkg::IRQ_WIDTH-1:0] ists_d;
    logic [slp_pkg::IRQ_WIDTH-1:0] ien_q;
    logic [slp_pkg::IRQ_WIDTH-1:0] ien_d;
    logic [slp_pkg::IRQ_WIDTH-1:0] iclr;
    logic [slp_pkg::IRQ_WIDTH-1:0] evt;
    logic irq_q;
    logic irq_d;
    logic [1:0] present_q;
    logic [1:0] insert_q;
    logic take_wr;
    logic take_rd;
    logic [31:0] status;

    always_comb begin
        status = '0;
        status[slp_pkg::STAT_SEL_LSB +: 2] = insert;
        status[slp_pkg::STAT_PRESENT_LSB +: 2] = present;
        status[slp_pkg::STAT_LOCKED_BIT] = (lock_q == slp_pkg::SLP_LOCKED);
        status[slp_pkg::STAT_REF_ALIVE_BIT] = ref_alive;
    end

    // Request answered one clock after it rises; wait drops for one edge
    always_comb begin
        take_wr = AVS_WRITE_IN && !wait_q;
        take_rd = AVS_READ_IN && !wait_q;
        wait_d = !((AVS_READ_IN || AVS_WRITE_IN) && wait_q);
        rdata_d = rdata_q;
        if (AVS_READ_IN && wait_q) begin
            if (AVS_ADDRESS_IN == slp_pkg::ADDR_CTRL) begin
                rdata_d = ctrl_q;
            end else if (AVS_ADDRESS_IN == slp_pkg::ADDR_STATUS) begin
                rdata_d = status;
            end else if (AVS_ADDRESS_IN == slp_pkg::ADDR_IRQ_STATUS) begin
                rdata_d = 32'(ists_q);
            end else if (AVS_ADDRESS_IN == slp_pkg::ADDR_IRQ_ENABLE) begin
                rdata_d = 32'(ien_q);
            end else if (AVS_ADDRESS_IN == slp_pkg::ADDR_ID) begin
                rdata_d = slp_pkg::ID_VALUE;
            end else begin
                rdata_d = 32'h0000_0000;
            end
        end
        ctrl_d = ctrl_q;
        ien_d = ien_q;
        iclr = '0;
        if (take_wr) begin
            if (AVS_ADDRESS_IN == slp_pkg::ADDR_CTRL) begin
                ctrl_d = AVS_WRITEDATA_IN;
            end else if (AVS_ADDRESS_IN == slp_pkg::ADDR_IRQ_CLEAR) begin
                iclr = AVS_WRITEDATA_IN[slp_pkg::IRQ_WIDTH-1:0];
            end else if (AVS_ADDRESS_IN == slp_pkg::ADDR_IRQ_ENABLE) begin
                ien_d = AVS_WRITEDATA_IN[slp_pkg::IRQ_WIDTH-1:0];
            end
        end
        // Relock bit self-clears so one write restarts acquisition once
        relock = ctrl_q[slp_pkg::CTRL_RELOCK_BIT];
        if (relock && !take_wr) begin
            ctrl_d[slp_pkg::CTRL_RELOCK_BIT] = 1'b0;
        end
        evt = '0;
        evt[slp_pkg::EVT_PRESENT_LSB +: 2] = present ^ present_q;
        evt[slp_pkg::EVT_LOCK_GAIN] = (lock_d == slp_pkg::SLP_LOCKED)
            && (lock_q == slp_pkg::SLP_ACQUIRE);
        evt[slp_pkg::EVT_LOCK_LOSS] = (lock_d == slp_pkg::SLP_ACQUIRE)
            && (lock_q == slp_pkg::SLP_LOCKED);
        evt[slp_pkg::EVT_SEL_CHANGE] = |(insert ^ insert_q);
        // A new event wins over a clear in the same cycle
        ists_d = (ists_q & ~iclr) | evt;
        irq_d = |(ists_d & ien_d);
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            dout_q <= 2'h0;
            lock_q <= slp_pkg::SLP_ACQUIRE;
            ref_q <= 1'b0;
            cnt_q <= '0;
            tmo_q <= '0;
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
            ctrl_q <= slp_pkg::CTRL_RESET;
            ists_q <= slp_pkg::IRQ_RESET;
            ien_q <= slp_pkg::IRQ_RESET;
            irq_q <= 1'b0;
            present_q <= 2'h0;
            insert_q <= 2'h3;
        end else begin
            dout_q <= dout_d;
            lock_q <= lock_d;
            ref_q <= ref_d;
            cnt_q <= cnt_d;
            tmo_q <= tmo_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            ctrl_q <= ctrl_d;
            ists_q <= ists_d;
            ien_q <= ien_d;
            irq_q <= irq_d;
            present_q <= present;
            insert_q <= insert;
        end
    end

    always_comb begin
        DRIVE_SIDE_OUTPUT_OUT = dout_q;
        SIGNAL_PRESENT_OUT = present;
        LOCKED_OUT = (lock_q == slp_pkg::SLP_LOCKED);
        AVS_READDATA_OUT = rdata_q;
        AVS_WAITREQUEST_OUT = wait_q;
        IRQ_OUT = irq_q;
    end
endmodule

// *** tb/slp_drive_model.sv ***
// Drive slot partner: a transceiver that sends back what it receives.
// Assumes one bit per system clock on both serial lines.
`timescale 1ns/10ps
module slp_drive_model (
    input wire logic clk_in,
    input wire logic present_in,
    input wire logic rx_in,
    output logic tx_out,
    output logic drive_low_out
);
    logic tx_q = 1'h0;
    // An empty slot drives nothing, so its line wanders every bit
    always @(posedge clk_in) begin
        tx_q <= present_in ? rx_in : ~tx_q;
    end
    assign tx_out = tx_q;
    // Fitted drive leaves select floating; empty slot pulls it low
    assign drive_low_out = !present_in;
endmodule

// *** tb/slp_mux_top_sva.sv ***
// Checker on the top level ports of the loop skip multiplexer.
// Assumes a floating select pin reads high.
`timescale 1ns/10ps
module slp_mux_top_sva #(
    parameter int LOCK_BITS = 2500
) (
    input wire logic CLK_SYS_IN,
    input wire logic RSTN_IN,
    input wire logic [1:0] DRIVE_SIDE_INPUT_IN,
    input wire logic [1:0] DRIVE_SIDE_OUTPUT_OUT,
    input wire logic [1:0] SKIP_N_IN,
    input wire logic [1:0] SKIP_N_DRIVEN_IN,
    input wire logic [11:0] INPUT0_AMP_MV_IN,
    input wire logic [11:0] INPUT1_AMP_MV_IN,
    input wire logic [1:0] SIGNAL_PRESENT_OUT,
    input wire logic LOCKED_OUT,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic AVS_WAITREQUEST_OUT
);
    logic [1:0] ins;
    logic cable;
    int run_d;
    int run_q;
    assign ins = SKIP_N_IN | ~SKIP_N_DRIVEN_IN;
    assign cable = ins[0] ? SIGNAL_PRESENT_OUT[1] : SIGNAL_PRESENT_OUT[0];
    // Cycles of unbroken cable signal, the floor for any lock
    always_comb begin
        run_d = cable ? run_q + 1 : 0;
    end
    always_ff @(posedge CLK_SYS_IN) begin
        run_q <= RSTN_IN ? run_d : 0;
    end
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!RSTN_IN);
    a_route_one: assert property (
        1'h1 |=> DRIVE_SIDE_OUTPUT_OUT[1] == $past(ins[0] ?
        DRIVE_SIDE_INPUT_IN[0] : DRIVE_SIDE_INPUT_IN[1]))
        else $error("node output 1 off route");
    a_route_zero: assert property (
        1'h1 |=> DRIVE_SIDE_OUTPUT_OUT[0] == $past(ins[1] ?
        DRIVE_SIDE_INPUT_IN[1] : DRIVE_SIDE_INPUT_IN[0]))
        else $error("node output 0 off route");
    a_present_on: assert property (
        INPUT0_AMP_MV_IN >= slp_pkg::PRESENT_ON_MV |=> SIGNAL_PRESENT_OUT[1])
        else $error("strong input not reported");
    a_present_off: assert property (
        INPUT1_AMP_MV_IN <= slp_pkg::PRESENT_OFF_MV
        |=> !SIGNAL_PRESENT_OUT[0]) else $error("weak input reported");
    a_wait_answer: assert property (
        (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
        |=> !AVS_WAITREQUEST_OUT) else $error("request not answered");
    a_wait_pulse: assert property (
        !AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
        else $error("waitrequest low too long");
    a_lock_loss: assert property (
        !cable && $stable(ins) |=> !LOCKED_OUT)
        else $error("lock kept without cable");
    a_lock_early: assert property (
        $rose(LOCKED_OUT) |-> run_q >= LOCK_BITS - 1)
        else $error("lock gained too early");
endmodule
bind slp_mux_top slp_mux_top_sva #(.LOCK_BITS(LOCK_BITS)) i_sva (
    .CLK_SYS_IN, .RSTN_IN, .DRIVE_SIDE_INPUT_IN, .DRIVE_SIDE_OUTPUT_OUT,
    .SKIP_N_IN, .SKIP_N_DRIVEN_IN, .INPUT0_AMP_MV_IN, .INPUT1_AMP_MV_IN,
    .SIGNAL_PRESENT_OUT, .LOCKED_OUT, .AVS_READ_IN, .AVS_WRITE_IN,
    .AVS_WAITREQUEST_OUT
);

// *** tb/test_serial_loop_port_skip_mux.sv ***
// Bench: loop source, drive slot model and bus master around the mux.
// Assumes LOCK_BITS cut to 20 so a lock takes 20 clocks once the cable is present.
`timescale 1ns/10ps
module test_serial_loop_port_skip_mux;
    localparam int LB = 20;
    logic clk = 1'h0, rstn = 1'h0, ref_clk = 1'h0, ref_en = 1'h1;
    logic exit_w = 1'h0, present = 1'h1, src_q = 1'h0, rd = 1'h0, wr = 1'h0;
    logic tx, sel_en, locked, irq, wreq;
    logic [1:0] din, dout, skip_n, skip_drv, sp;
    logic [11:0] amp0 = 12'h000, amp1 = 12'h000;
    logic [11:0] amps [5];
    logic [7:0] addr = 8'h00, hist_q = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v;
    int n_errors = 0, samples_checked = 0;
    always #20 clk = ~clk;
    // Fixed feedback pattern, so lags of one and three bits differ
    always @(posedge clk) begin
        src_q <= hist_q[3] ^ ~hist_q[5];
        hist_q <= {hist_q[6:0], src_q};
        ref_clk <= ref_clk ^ ref_en;
    end
    assign din = exit_w ? {src_q, tx} : {tx, src_q};
    assign skip_drv = exit_w ? {1'h0, sel_en} : {sel_en, 1'h0};
    assign skip_n = exit_w ? {1'h1, ~sel_en} : {~sel_en, 1'h1};
    slp_mux_top #(.LOCK_BITS(LB)) i_dut (
        .CLK_SYS_IN(clk), .RSTN_IN(rstn), .REF_CLK_IN(ref_clk),
        .DRIVE_SIDE_INPUT_IN(din), .DRIVE_SIDE_OUTPUT_OUT(dout),
        .SKIP_N_IN(skip_n), .SKIP_N_DRIVEN_IN(skip_drv),
        .INPUT0_AMP_MV_IN(amp0), .INPUT1_AMP_MV_IN(amp1),
        .SIGNAL_PRESENT_OUT(sp), .LOCKED_OUT(locked),
        .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
        .AVS_WRITEDATA_IN(wdata), .AVS_READDATA_OUT(rdata),
        .AVS_WAITREQUEST_OUT(wreq), .IRQ_OUT(irq));
    slp_drive_model i_drive (.clk_in(clk), .present_in(present),
        .rx_in(dout[!exit_w]), .tx_out(tx), .drive_low_out(sel_en));
    task automatic check(string nm, logic [31:0] s, logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, e, s);
        end
    endtask
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do @(posedge clk); while (wreq !== 1'h0);
        v = rdata;
        rd <= 1'h0;
        wr <= 1'h0;
    endtask
    task automatic stream(logic ex, logic pr, int lag);
        @(posedge clk);
        exit_w <= ex;
        present <= pr;
        repeat (5) @(negedge clk);
        repeat (12) begin
            @(negedge clk);
            check("cable out", dout[ex], hist_q[lag-1]);
            check("pass out", dout[!ex], hist_q[0]);
        end
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #(40 * 4000);
        n_errors++;
        print_verdict();
    end
    initial begin
        amps = '{slp_pkg::PRESENT_ON_MV, slp_pkg::PRESENT_ON_MV - 12'h001,
            slp_pkg::PRESENT_OFF_MV, slp_pkg::PRESENT_OFF_MV + 12'h001,
            12'h000};
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("reset outs", {wreq, irq, locked, sp, dout}, 7'h40);
        @(posedge clk);
        rstn <= 1'h1;
        bus(1'h0, slp_pkg::ADDR_ID, 32'h0);
        check("id", v, slp_pkg::ID_VALUE);
        bus(1'h1, 8'h20, 32'hFFFF_FFFF);
        bus(1'h0, 8'h20, 32'h0);
        check("unmapped", v, 32'h0);
        bus(1'h1, slp_pkg::ADDR_IRQ_CLEAR, 32'h1F);
        bus(1'h1, slp_pkg::ADDR_IRQ_ENABLE, 32'h10);
        bus(1'h0, slp_pkg::ADDR_IRQ_ENABLE, 32'h0);
        check("enable", v, 32'h0000_0010);
        // Clear register is write-only and must read back as zero
        bus(1'h0, slp_pkg::ADDR_IRQ_CLEAR, 32'h0);
        check("clear reads", v, 32'h0000_0000);
        stream(1'h0, 1'h1, 3);
        stream(1'h0, 1'h0, 1);
        check("irq", irq, 1'h1);
        bus(1'h0, slp_pkg::ADDR_STATUS, 32'h0);
        check("selects", v[1:0], 2'h1);
        bus(1'h1, slp_pkg::ADDR_IRQ_CLEAR, 32'h10);
        bus(1'h1, slp_pkg::ADDR_IRQ_ENABLE, 32'h0);
        stream(1'h0, 1'h1, 3);
        check("irq masked", irq, 1'h0);
        bus(1'h0, slp_pkg::ADDR_IRQ_STATUS, 32'h0);
        check("sel event", v[4], 1'h1);
        foreach (amps[i]) begin
            @(posedge clk);
            amp0 <= amps[i];
            amp1 <= amps[i];
            repeat (2) @(negedge clk);
            check("present", sp, {2{i < 2}});
        end
        @(posedge clk);
        amp0 <= slp_pkg::PRESENT_ON_MV;
        repeat (LB - 4) @(negedge clk);
        check("early lock", locked, 1'h0);
        repeat (10) @(negedge clk);
        check("lock", {sp, locked}, 3'h5);
        @(posedge clk);
        ref_en <= 1'h0;
        repeat (14) @(negedge clk);
        check("ref lost", locked, 1'h0);
        @(posedge clk);
        ref_en <= 1'h1;
        repeat (LB + 10) @(negedge clk);
        check("relock", locked, 1'h1);
        // Software restart: lock drops, bit self-clears, lock returns
        bus(1'h1, slp_pkg::ADDR_CTRL, 32'h1);
        repeat (2) @(negedge clk);
        check("relock cmd", locked, 1'h0);
        bus(1'h0, slp_pkg::ADDR_CTRL, 32'h0);
        check("relock clears", v, slp_pkg::CTRL_RESET);
        repeat (LB + 4) @(negedge clk);
        check("lock again", locked, 1'h1);
        @(posedge clk);
        amp0 <= 12'h000;
        repeat (3) @(negedge clk);
        check("loss", locked, 1'h0);
        stream(1'h1, 1'h1, 3);
        stream(1'h1, 1'h0, 1);
        print_verdict();
    end
endmodule
